// ===== inc/dbp_pkg.sv
// constants and types shared by the dual bridge control logic
`default_nettype none
package dbp_pkg;
    localparam int unsigned CLK_HZ = 40_000_000; // core clock rate
    localparam int unsigned CLK_NS = 25; // core clock period in ns
    // durations as printed, in their own units
    localparam int unsigned T_OFF_NS = 25_000; // constant off-time, typical
    localparam int unsigned T_BLANK_NS = 3_000; // blanking after turn-on, typical
    localparam int unsigned T_COD_NS = 50; // crossover dead time, least
    localparam int unsigned T_STBY_US = 1_000; // standby qualification interval
    localparam int unsigned T_PU_US = 30; // charge pump settle, host side
    // cycle counts derived from the rate
    localparam int unsigned OFF_CYC = T_OFF_NS / CLK_NS;
    localparam int unsigned BLANK_CYC = T_BLANK_NS / CLK_NS;
    localparam int unsigned COD_CYC = (T_COD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned STBY_CYC = (T_STBY_US * 1000) / CLK_NS;
    localparam int unsigned PU_CYC = (T_PU_US * 1000) / CLK_NS;
    localparam int unsigned CNT_W = 16; // bridge timer width
    localparam int unsigned STBY_W = 20; // standby timer width
    // bridge phase states
    typedef enum logic [2:0]
    {
        DBP_IDLE,
        DBP_DRIVE,
        DBP_FAST,
        DBP_DEAD,
        DBP_SLOW
    } dbp_phase_t;
endpackage
`default_nettype wire

// ===== src/dbp_bridge.sv
// one full bridge: decode, fixed off-time chopping, protection hold-off
`default_nettype none
module dbp_bridge
    import dbp_pkg::*;
#(
    parameter int unsigned OFF_N = OFF_CYC,
    parameter int unsigned BLANK_N = BLANK_CYC,
    parameter int unsigned COD_N = COD_CYC
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic phase_in_i, // synchronised first input
    input wire logic return_in_i, // synchronised second input
    input wire logic trip_i, // synchronised sense comparator
    input wire logic zero_cur_i, // synchronised zero current detect
    input wire logic disable_i, // fault, thermal, lockout or standby
    output logic left_drive_o, // left level
    output logic right_drive_o, // right level
    output logic left_oe_n_o, // low while left is driven
    output logic right_oe_n_o // low while right is driven
);
    import dbp_pkg::*;

    // refuse counts the timer cannot hold; dead time must end inside the off-time
    if (OFF_N < 2 || OFF_N >= (1 << CNT_W) || BLANK_N >= (1 << CNT_W) || COD_N < 1
        || COD_N >= OFF_N / 2)
    begin : g_bad_count
        $error("dbp_bridge: timing count out of range");
    end

    typedef struct packed {
        dbp_phase_t phase;
        logic [CNT_W-1:0] tmr; // off-time or blanking counter
        logic [CNT_W-1:0] dead; // dead time counter
        logic sr_on; // synchronous rectification allowed
        logic l, r, loe_n, roe_n;
    } dbp_br_t;

    dbp_br_t st;
    dbp_br_t next_st;

    localparam logic [CNT_W-1:0] HALF_N = CNT_W'(OFF_N / 2);

    // next state and output decode
    always_comb
    begin
        logic fwd;
        logic rev;
        fwd = phase_in_i & ~return_in_i;
        rev = ~phase_in_i & return_in_i;
        next_st = st;
        case (st.phase)
            DBP_IDLE:
            begin
                // drive cycle starts with the diagonal pair on [R8]
                if (fwd || rev)
                begin
                    next_st.phase = DBP_DRIVE;
                    next_st.tmr = CNT_W'(BLANK_N);
                end
            end
            DBP_DRIVE:
            begin
                if (!(fwd || rev))
                    next_st.phase = DBP_IDLE;
                else if (st.tmr != '0)
                    next_st.tmr = st.tmr - 1'b1; // comparator masked [R17]
                else if (trip_i)
                begin
                    // trip resets the latch, decay begins [R8] [R9]
                    next_st.phase = DBP_FAST;
                    next_st.tmr = CNT_W'(OFF_N - 1);
                    next_st.sr_on = 1'b1;
                end
            end
            DBP_FAST:
            begin
                next_st.tmr = st.tmr - 1'b1;
                if (zero_cur_i)
                    next_st.sr_on = 1'b0; // stop before current reverses [R12]
                if (st.tmr == HALF_N)
                begin
                    // half the off-time spent, go dead [R10] [R11]
                    next_st.phase = DBP_DEAD;
                    next_st.dead = CNT_W'(COD_N - 1);
                end
            end
            DBP_DEAD:
            begin
                next_st.tmr = st.tmr - 1'b1;
                next_st.dead = st.dead - 1'b1;
                // re-arm for slow decay unless the current is already at zero [R12]
                next_st.sr_on = ~zero_cur_i;
                if (st.dead == '0)
                    next_st.phase = DBP_SLOW;
            end
            DBP_SLOW:
            begin
                if (zero_cur_i)
                    next_st.sr_on = 1'b0; // [R12]
                if (st.tmr == '0)
                begin
                    // off-time over: re-enable drive [R9]
                    next_st.phase = DBP_DRIVE;
                    next_st.tmr = CNT_W'(BLANK_N);
                    next_st.sr_on = 1'b0;
                end
                else
                    next_st.tmr = st.tmr - 1'b1;
            end
            default:
                next_st.phase = DBP_IDLE;
        endcase
        if (disable_i || (!(fwd || rev) && st.phase != DBP_IDLE))
        begin
            next_st.phase = DBP_IDLE;
            next_st.sr_on = 1'b0;
        end
        // output decode, registered next cycle
        next_st.l = 1'b0;
        next_st.r = 1'b0;
        next_st.loe_n = 1'b1;
        next_st.roe_n = 1'b1;
        if (disable_i)
        begin
            // protection keeps both sides floating [R19] [R16] [R15] [R13]
        end
        else if (phase_in_i && return_in_i)
        begin
            // brake: both low, slow decay [R3]
            next_st.loe_n = 1'b0;
            next_st.roe_n = 1'b0;
        end
        else if (fwd || rev)
        begin
            case (next_st.phase)
                DBP_DRIVE:
                begin
                    // forward high-low, reverse low-high [R1]
                    next_st.l = fwd;
                    next_st.r = rev;
                    next_st.loe_n = 1'b0;
                    next_st.roe_n = 1'b0;
                end
                DBP_FAST:
                begin
                    // fast decay: reversed diagonal, mixed decay chop [R2]
                    next_st.l = rev;
                    next_st.r = fwd;
                    next_st.loe_n = ~next_st.sr_on;
                    next_st.roe_n = ~next_st.sr_on;
                end
                DBP_SLOW:
                begin
                    // slow decay: both low sides on while rectifying [R2] [R12]
                    next_st.loe_n = ~next_st.sr_on;
                    next_st.roe_n = ~next_st.sr_on;
                end
                default:
                begin
                    // dead time: every driver off [R11]
                end
            endcase
        end
        // both inputs low: coast, both floating [R4]
    end

    // single state register
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '{phase: DBP_IDLE, tmr: '0, dead: '0, sr_on: 1'b0,
                    l: 1'b0, r: 1'b0, loe_n: 1'b1, roe_n: 1'b1};
        end
        else
            st <= next_st;
    end

    assign left_drive_o = st.l;
    assign right_drive_o = st.r;
    assign left_oe_n_o = st.loe_n;
    assign right_oe_n_o = st.roe_n;

    a_dead_all_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R11]
        st.phase == DBP_DEAD |-> (st.loe_n && st.roe_n))
        else $error("drivers on during dead time");
    a_disable_float: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R19]
        disable_i |=> (st.loe_n && st.roe_n))
        else $error("outputs driven while disabled");
    a_fast_to_dead: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R10]
        (st.phase == DBP_FAST && st.tmr == HALF_N && !disable_i
         && (phase_in_i ^ return_in_i)) |=> st.phase == DBP_DEAD)
        else $error("fast decay did not end at half off-time");
    a_blank_ignore: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R17]
        (st.phase == DBP_DRIVE && st.tmr != '0) |=> st.phase != DBP_FAST)
        else $error("trip taken during blanking");
    c_chop: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        st.phase == DBP_FAST ##[1:1000] st.phase == DBP_SLOW);
endmodule
`default_nettype wire

// ===== src/dbp_top.sv
// dual bridge control: input sync, standby timer, fault latches, two bridges
//
// Contract
// [R1] forward/reverse inputs give opposite output levels
// [R2] trip while driving chops in mixed decay
// [R3] both inputs high: both outputs low
// [R4] both inputs low: both outputs float
// [R5] standby after all inputs low interval
// [R6] standby switches off pump and regulator
// [R7] host waits pump settle before PWM; the host model only drops ready_o, pins follow cmd_i
// [R8] drive starts diagonal; trip starts decay
// [R9] fixed off-time then drive again
// [R10] fast decay first half, then slow
// [R11] all drivers off at fast-slow crossover
// [R12] rectify during decay, stop at zero
// [R13] short latches per-channel fault, outputs off
// [R14] fault clears leaving standby or power-cycle
// [R15] over-temperature disables outputs until clear
// [R16] supply lockout keeps drivers off
// [R17] ignore comparator during blanking after turn-on
// [R18] durations are configurable cycle counts
// [R19] disabled bridge outputs held floating
`default_nettype none
module dbp_top
    import dbp_pkg::*;
#(
    parameter int unsigned OFF_N = dbp_pkg::OFF_CYC, // off-time cycles [R18]
    parameter int unsigned BLANK_N = dbp_pkg::BLANK_CYC, // blanking cycles [R18]
    parameter int unsigned COD_N = dbp_pkg::COD_CYC, // dead time cycles [R18]
    parameter int unsigned STBY_N = dbp_pkg::STBY_CYC // standby cycles [R18]
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i, // power-up reset, also models supply cycling
    input wire logic bridge_a_phase_in_i,
    input wire logic bridge_a_return_in_i,
    input wire logic bridge_b_phase_in_i,
    input wire logic bridge_b_return_in_i,
    input wire logic [1:0] sense_trip_i, // ten times sense above reference
    input wire logic [1:0] zero_current_i, // decay current reached zero
    input wire logic [1:0] short_detect_i, // output short seen
    input wire logic over_temp_i, // thermal indication with hysteresis
    input wire logic supply_low_lockout_i, // load supply lockout
    output logic bridge_a_left_drive_o,
    output logic bridge_a_right_drive_o,
    output logic bridge_a_left_oe_n_o,
    output logic bridge_a_right_oe_n_o,
    output logic bridge_b_left_drive_o,
    output logic bridge_b_right_drive_o,
    output logic bridge_b_left_oe_n_o,
    output logic bridge_b_right_oe_n_o,
    output logic standby_o, // in low power standby
    output logic pump_enable_o, // charge pump and regulator on
    output logic [1:0] short_circuit_fault_o // latched fault per channel
);
    import dbp_pkg::*;

    // the standby count must fit its timer
    if (STBY_N < 1 || STBY_N >= (1 << STBY_W))
    begin : g_bad_stby
        $error("dbp_top: standby count out of range");
    end

    localparam int unsigned NIN = 12; // synchronised pin count

    typedef struct packed {
        logic [NIN-1:0] s1; // first sync stage, read only by s2
        logic [NIN-1:0] s2; // second sync stage
        logic [STBY_W-1:0] stby_cnt; // all-low qualification
        logic stby;
        logic pump; // own flop so the output needs no inverter
        logic [1:0] fault;
    } dbp_top_t;

    dbp_top_t st;
    dbp_top_t next_st;

    logic [NIN-1:0] pins;
    logic in_a_ph, in_a_rt, in_b_ph, in_b_rt;
    logic [1:0] trip_s, zero_s, short_s;
    logic ot_s, uv_s;
    logic all_low;
    logic [1:0] dis;

    assign pins = {supply_low_lockout_i, over_temp_i, short_detect_i, zero_current_i,
                   sense_trip_i, bridge_b_return_in_i, bridge_b_phase_in_i,
                   bridge_a_return_in_i, bridge_a_phase_in_i};
    assign {uv_s, ot_s, short_s, zero_s, trip_s, in_b_rt, in_b_ph, in_a_rt, in_a_ph} = st.s2;
    assign all_low = ~(in_a_ph | in_a_rt | in_b_ph | in_b_rt);

    // next state: sync chain, standby timer, fault latches
    always_comb
    begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        if (!all_low)
        begin
            // any high input restarts qualification and leaves standby [R5]
            next_st.stby_cnt = '0;
            next_st.stby = 1'b0;
            if (st.stby)
                next_st.fault = 2'b00; // leaving standby clears faults [R14]
        end
        else if (st.stby_cnt >= STBY_W'(STBY_N))
            next_st.stby = 1'b1; // held low longer than interval [R5]
        else
            next_st.stby_cnt = st.stby_cnt + 1'b1;
        // set wins over the standby-exit clear [R13]
        next_st.fault = next_st.fault | short_s;
        // pump and regulator follow standby on the same edge [R6]
        next_st.pump = ~next_st.stby;
    end

    // the only state register
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st <= '{s1: '0, s2: '0, stby_cnt: '0, stby: 1'b0, pump: 1'b1, fault: 2'b00};
        else
            st <= next_st;
    end

    // per-channel disable from fault, heat, lockout or standby [R13] [R15] [R16]
    assign dis[0] = st.fault[0] | ot_s | uv_s | st.stby;
    assign dis[1] = st.fault[1] | ot_s | uv_s | st.stby;

    // bridge A
    dbp_bridge #(
        .OFF_N(OFF_N),
        .BLANK_N(BLANK_N),
        .COD_N(COD_N)
    ) u_bridge_a (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .phase_in_i(in_a_ph),
        .return_in_i(in_a_rt),
        .trip_i(trip_s[0]),
        .zero_cur_i(zero_s[0]),
        .disable_i(dis[0]),
        .left_drive_o(bridge_a_left_drive_o),
        .right_drive_o(bridge_a_right_drive_o),
        .left_oe_n_o(bridge_a_left_oe_n_o),
        .right_oe_n_o(bridge_a_right_oe_n_o)
    );

    // bridge B, independent regulation [R9]
    dbp_bridge #(
        .OFF_N(OFF_N),
        .BLANK_N(BLANK_N),
        .COD_N(COD_N)
    ) u_bridge_b (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .phase_in_i(in_b_ph),
        .return_in_i(in_b_rt),
        .trip_i(trip_s[1]),
        .zero_cur_i(zero_s[1]),
        .disable_i(dis[1]),
        .left_drive_o(bridge_b_left_drive_o),
        .right_drive_o(bridge_b_right_drive_o),
        .left_oe_n_o(bridge_b_left_oe_n_o),
        .right_oe_n_o(bridge_b_right_oe_n_o)
    );

    // status straight from flops; pump off in standby [R6]
    assign standby_o = st.stby;
    assign pump_enable_o = st.pump;
    assign short_circuit_fault_o = st.fault;

    a_stby_entry: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R5]
        !all_low ##1 all_low [*8] |-> !st.stby)
        else $error("standby entered too early");
    a_fault_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R14]
        (st.fault != 2'b00 && !st.stby) |=> (st.fault & $past(st.fault)) == $past(st.fault))
        else $error("fault cleared without standby exit");
    a_fault_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R13]
        short_s[1] |=> st.fault[1])
        else $error("short not latched");
    a_heat_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R15]
        ot_s |=> (bridge_a_left_oe_n_o && bridge_b_right_oe_n_o))
        else $error("drive while over temperature");
    a_pump_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [R6]
        st.stby |-> !pump_enable_o)
        else $error("pump on in standby");
    c_standby: cover property (@(posedge core_clk_i) disable iff (!resetn_i) st.stby);
    c_fault: cover property (@(posedge core_clk_i) disable iff (!resetn_i) st.fault == 2'b11);
    c_brake: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        in_a_ph && in_a_rt && !dis[0]);
endmodule
`default_nettype wire

// ===== verif/dbp_host_model.sv
// host controller model driving the four bridge command pins
`default_nettype none
module dbp_host_model
    import dbp_pkg::*;
#(
    parameter int unsigned PU_N = PU_CYC // pump settle wait in cycles
)
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] cmd_i, // wanted pins {b_ret, b_ph, a_ret, a_ph}
    input wire logic standby_i, // device reports standby
    output logic [3:0] pins_o, // pins as driven
    output logic ready_o // high once the settle wait is over
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned wait_cnt; // cycles left before pwm may be trusted
    logic was_stby; // standby seen on the last edge
    // pins move just after the edge, like a real controller output
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pins_o <= 4'h0;
            wait_cnt <= 0;
            was_stby <= 1'b0;
        end
        else
        begin
            pins_o <= cmd_i;
            was_stby <= standby_i;
            // the pump needs time after wake, so ready_o stays low for PU_N cycles
            if (was_stby && !standby_i)
            begin
                wait_cnt <= PU_N;
            end
            else if (wait_cnt != 0)
            begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
    assign ready_o = (wait_cnt == 0);
endmodule
`default_nettype wire

// ===== verif/test_dual_bridge_pwm_control.sv
// self-checking bench for the dual bridge control logic
`default_nettype none
module test_dual_bridge_pwm_control;
    timeunit 1ns;
    timeprecision 1ps;
    import dbp_pkg::*;
    // short counts keep the run brief
    localparam int unsigned OFF_T = 20;
    localparam int unsigned BLANK_T = 3;
    localparam int unsigned COD_T = 2;
    localparam int unsigned STBY_T = 50;
    localparam int LIMIT = 20000; // hang ceiling in cycles
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] cmd, pins, c, obs_a, obs_b, prev;
    logic ready, hot, sup_low, al, ar, aloe, aroe, bl, br, bloe, broe, stby, pump;
    logic [1:0] trip, zc, shrt, flt;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int run, min_drive, max_dead, nfast, nslow, reent;
    // drive levels mean nothing while both sides float
    function automatic logic [3:0] norm(input logic [3:0] v);
        return (v[1:0] === 2'b11) ? 4'b0011 : v;
    endfunction
    // expected {left, right, left_oe_n, right_oe_n} for {phase, return}
    function automatic logic [3:0] want(input logic [1:0] pr);
        case (pr)
            2'b10: return 4'b1000; // forward
            2'b01: return 4'b0100; // reverse
            2'b11: return 4'b0000; // brake
            default: return 4'b0011; // coast
        endcase
    endfunction
    assign obs_a = norm({al, ar, aloe, aroe});
    assign obs_b = norm({bl, br, bloe, broe});
    dbp_host_model i_host (
        .core_clk_i(core_clk),
        .resetn_i(resetn),
        .cmd_i(cmd),
        .standby_i(stby),
        .pins_o(pins),
        .ready_o(ready)
    );
    dbp_top #(.OFF_N(OFF_T), .BLANK_N(BLANK_T), .COD_N(COD_T), .STBY_N(STBY_T)) i_dut (
        .core_clk_i(core_clk),
        .resetn_i(resetn),
        .bridge_a_phase_in_i(pins[0]),
        .bridge_a_return_in_i(pins[1]),
        .bridge_b_phase_in_i(pins[2]),
        .bridge_b_return_in_i(pins[3]),
        .sense_trip_i(trip),
        .zero_current_i(zc),
        .short_detect_i(shrt),
        .over_temp_i(hot),
        .supply_low_lockout_i(sup_low),
        .bridge_a_left_drive_o(al),
        .bridge_a_right_drive_o(ar),
        .bridge_a_left_oe_n_o(aloe),
        .bridge_a_right_oe_n_o(aroe),
        .bridge_b_left_drive_o(bl),
        .bridge_b_right_drive_o(br),
        .bridge_b_left_oe_n_o(bloe),
        .bridge_b_right_oe_n_o(broe),
        .standby_o(stby),
        .pump_enable_o(pump),
        .short_circuit_fault_o(flt)
    );
    // 40 MHz core clock
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard: counts as a mismatch
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // new command lands on a rising edge
    task automatic drive(input logic [3:0] v);
        @(posedge core_clk);
        cmd <= v;
    endtask
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        cmd = 4'h0;
        trip = 2'b00;
        zc = 2'b00;
        shrt = 2'b00;
        hot = 1'b0;
        sup_low = 1'b0;
        void'($urandom(32'hebf2));
        tick(10);
        chk("reset float", 4'b0011, obs_a);
        resetn <= 1'b1;
        // every pattern once, then random ones
        for (int i = 0; i < 40; i++)
        begin
            c = (i < 16) ? 4'(i) : 4'($urandom_range(15));
            drive(c);
            tick(6);
            chk("bridge a", want({c[0], c[1]}), obs_a);
            chk("bridge b", want({c[2], c[3]}), obs_b);
        end
        $display("test truth table done");
        // a forward with trip held, b reverse untouched
        drive(4'b1001);
        tick(6);
        trip <= 2'b01;
        prev = obs_a;
        run = 0;
        min_drive = 999;
        max_dead = 0;
        nfast = 0;
        nslow = 0;
        reent = 0;
        for (int i = 0; i < 3 * OFF_T; i++)
        begin
            @(posedge core_clk);
            nfast += int'(obs_a === 4'b0100);
            nslow += int'(obs_a === 4'b0000);
            if (obs_a === prev)
                run++;
            else
            begin
                if (prev === 4'b0011 && run > max_dead)
                    max_dead = run;
                if (prev === 4'b1000 && reent > 0 && run < min_drive)
                    min_drive = run;
                if (obs_a === 4'b1000)
                    reent++;
                prev = obs_a;
                run = 1;
            end
        end
        chk("fast decay seen", 4'h1, 4'(nfast > 0));
        chk("fast before slow", 4'h1, 4'(nslow > 0 && nfast >= nslow));
        chk("dead time", 4'h1, 4'(max_dead == COD_T));
        chk("drive again", 4'h1, 4'(reent >= 2));
        chk("blanking", 4'h1, 4'(min_drive >= BLANK_T && min_drive < 999));
        chk("other bridge", 4'b0100, obs_b);
        // zero current ends rectification
        run = 0;
        while (obs_a !== 4'b0100 && run < 100)
        begin
            @(posedge core_clk);
            run++;
        end
        zc <= 2'b01;
        tick(4);
        chk("zero current", 4'b0011, obs_a);
        zc <= 2'b00;
        trip <= 2'b00;
        tick(2 * OFF_T);
        chk("drive restored", 4'b1000, obs_a);
        $display("test chopping done");
        // thermal then supply lockout
        for (int k = 0; k < 2; k++)
        begin
            @(posedge core_clk);
            hot <= (k == 0);
            sup_low <= (k == 1);
            tick(6);
            chk("off a", 4'b0011, obs_a);
            chk("off b", 4'b0011, obs_b);
            hot <= 1'b0;
            sup_low <= 1'b0;
            tick(6);
            chk("back b", 4'b0100, obs_b);
        end
        $display("test protection done");
        // short on b latches, survives input changes
        @(posedge core_clk);
        shrt <= 2'b10;
        tick(2);
        shrt <= 2'b00;
        tick(6);
        chk("fault b", 4'b0010, {2'b00, flt});
        chk("b floats", 4'b0011, obs_b);
        chk("a runs", 4'b1000, obs_a);
        drive(4'b0000);
        tick(STBY_T - 10);
        drive(4'b0001);
        tick(2);
        drive(4'b0000);
        tick(STBY_T - 10);
        chk("no early standby", 4'b0001, {2'b00, stby, pump});
        tick(20);
        chk("standby", 4'b0010, {2'b00, stby, pump});
        chk("fault kept", 4'b0010, {2'b00, flt});
        drive(4'b1001);
        tick(6);
        chk("awake", 4'b0001, {2'b00, stby, pump});
        chk("fault cleared", 4'b0000, {2'b00, flt});
        run = 0;
        while (!ready && run < 2000)
        begin
            @(posedge core_clk);
            run++;
        end
        chk("settle wait", 4'h1, 4'(ready && run > 0 && run <= PU_CYC));
        chk("b drives", 4'b0100, obs_b);
        $display("test fault and standby done");
        end_of_test();
    end
endmodule
`default_nettype wire
